// ==== dv/ebs_far_model.sv ====
// Purpose : Far-side model: ready source and a second bus master
// Assumes : Bench changes rdy_mode and want_bus at the falling edge
// Notes   : Ready modes are 0 low, 1 high, 2 looped from wait_progress_out

`timescale 1ns/1ps

module ebs_far_model (
    // Clock
    input  wire logic       clk_sys,
    // Control from the bench
    input  wire logic [1:0] rdy_mode,
    input  wire logic       want_bus,
    // Pins seen from the device
    input  wire logic       wait_progress_out,
    input  wire logic       status_oe,
    input  wire logic       bus_hold_ack,
    // Pins driven towards the device
    output logic            ready,
    output logic            hold_req_n,
    output logic            drive_bus
);
    // ------------------------------------------------------------------
    // Ready source
    // ------------------------------------------------------------------
    // A floated loop-back wire rests at its pull-up, so it reads as ready
    assign ready = (rdy_mode == 2'h2) ? (status_oe ? wait_progress_out : 1'h1)
                                      : rdy_mode[0];

    // ------------------------------------------------------------------
    // Second master
    // ------------------------------------------------------------------
    // Drives only after acknowledge; lets go of the bus before the request.
    // One process owns both pins so each has a single driver.
    initial begin
        hold_req_n = 1'h1;
        drive_bus  = 1'h0;
        forever begin
            @(negedge clk_sys);
            if (want_bus) begin
                hold_req_n <= 1'h0;
                if (bus_hold_ack === 1'h1 && !hold_req_n) begin
                    drive_bus <= 1'h1;
                end
            end else if (drive_bus) begin
                drive_bus <= 1'h0;
            end else begin
                hold_req_n <= 1'h1;
            end
        end
    end
endmodule

// ==== dv/ext_mem_bus_status_ctrl_bench.sv ====
// Purpose : Self-checking bench for the bus status block
// Assumes : Inputs change at the falling edge of clk_sys
// Notes   : Access length is counted in clk_sys cycles with a strobe low

`timescale 1ns/1ps

module ext_mem_bus_status_ctrl_bench;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic       clk_sys = 1'h0;       // 40 MHz system clock
    logic       rstn;                 // Asynchronous reset, active low
    logic       acc_req, acc_instr, acc_write, acc_done;
    logic [2:0] acc_sw_waits;         // Software wait count
    logic [1:0] acc_space, rdy_mode;  // Space code, far-side ready mode
    logic       hold_req_n, ready, off_n, want_bus, drive_bus;
    logic       bus_hold_ack, wait_progress_out, instr_fetch_ind_n;
    logic       machine_cycle_clk_out, status_oe, ctl_oe;
    logic       mem_strobe_n, io_strobe_n;
    logic       data_space_sel_n, prog_space_sel_n, io_space_sel_n, rd_wr;
    logic [5:0] ctl_pins;             // Selects, strobes and rd_wr as one word
    logic       prev_clk, prev_ok;    // Clock-output monitor history
    int         bad_count = 0;
    int         n_checks = 0;

    always #12.5 clk_sys = ~clk_sys;  // Half of the 25 ns period

    assign ctl_pins = {prog_space_sel_n, data_space_sel_n, io_space_sel_n, mem_strobe_n,
                       io_strobe_n, rd_wr};

    ebs_bus_status dut_u (
        .clk_sys(clk_sys), .rstn(rstn), .acc_req(acc_req), .acc_sw_waits(acc_sw_waits),
        .acc_instr(acc_instr), .acc_space(acc_space), .acc_write(acc_write),
        .acc_done(acc_done), .hold_req_n(hold_req_n), .ready(ready), .off_n(off_n),
        .bus_hold_ack(bus_hold_ack), .wait_progress_out(wait_progress_out),
        .instr_fetch_ind_n(instr_fetch_ind_n), .machine_cycle_clk_out(machine_cycle_clk_out),
        .status_oe(status_oe), .mem_strobe_n(mem_strobe_n), .io_strobe_n(io_strobe_n),
        .data_space_sel_n(data_space_sel_n), .prog_space_sel_n(prog_space_sel_n),
        .io_space_sel_n(io_space_sel_n), .rd_wr(rd_wr), .ctl_oe(ctl_oe));

    ebs_far_model far_u (
        .clk_sys(clk_sys), .rdy_mode(rdy_mode), .want_bus(want_bus),
        .wait_progress_out(wait_progress_out), .status_oe(status_oe),
        .bus_hold_ack(bus_hold_ack), .ready(ready), .hold_req_n(hold_req_n),
        .drive_bus(drive_bus));

    // ------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------
    task automatic check(input logic ok, input string msg);
        n_checks++;
        // An unknown result counts as a mismatch
        if (ok !== 1'h1) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic stop_test();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Expected strobe-low cycles: one machine cycle plus waits, plus the loop wait
    function automatic int exp_len(input logic [2:0] n, input logic [1:0] m);
        return 2 * (1 + int'(n) + ((m == 2'h2 && n >= ebs_pkg::WAIT_MIN_RDY) ? 1 : 0));
    endfunction

    // Expected {prog, data, io selects, memory and I/O strobes, rd_wr} during an access
    function automatic logic [5:0] exp_pins(input logic [1:0] sp, input logic wr);
        return {sp != ebs_pkg::SPACE_PROG, sp != ebs_pkg::SPACE_DATA, sp != ebs_pkg::SPACE_IO,
                sp == ebs_pkg::SPACE_IO, sp != ebs_pkg::SPACE_IO, !wr};
    endfunction

    // Clock output must change at every rising system clock edge
    always @(negedge clk_sys) begin
        if (prev_ok) begin
            check(machine_cycle_clk_out !== prev_clk, "clock output stuck");
        end
        prev_clk <= machine_cycle_clk_out;
        prev_ok  <= rstn;
    end

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic start_acc(input logic [2:0] n, input logic ins, input logic [1:0] sp,
                             input logic wr);
        @(negedge clk_sys);
        acc_sw_waits = n;
        acc_instr    = ins;
        acc_space    = sp;
        acc_write    = wr;
        acc_req      = 1'h1;
    endtask

    // ev: 0 plain, 1 ready stalled low, 2 hold requested mid-access
    task automatic finish_acc(input logic [2:0] n, input logic ins, input logic [1:0] m,
                              input int ev);
        int   act, wcnt, first_w, i;
        logic done;
        act = 0;
        wcnt = 0;
        first_w = -1;
        done = 1'h0;
        for (i = 0; i < 300 && !done; i++) begin
            @(negedge clk_sys);
            if (ev == 1 && i == 60) begin
                check(act > 0 && acc_done === 1'h0, "ended while ready low");
                rdy_mode = 2'h1;
            end
            if (ev == 2 && i == 3) begin
                want_bus = 1'h1;
            end
            if ((mem_strobe_n & io_strobe_n) === 1'h0) begin
                check(instr_fetch_ind_n === !ins, "fetch indicator wrong");
                check(ctl_pins === exp_pins(acc_space, acc_write), "select pins wrong");
                check(bus_hold_ack === 1'h0, "acknowledge during access");
                if (wait_progress_out === 1'h0) begin
                    first_w = (first_w < 0) ? act : first_w;
                    wcnt++;
                end
                act++;
            end else begin
                check(instr_fetch_ind_n === 1'h1, "fetch indicator not high");
                check(ctl_pins === 6'h3F, "select pins not at rest");
            end
            done = (acc_done === 1'h1);
        end
        acc_req = 1'h0;
        if (!done) begin
            check(1'h0, "access never finished");
            stop_test();
        end
        if (ev != 1) begin
            check(act == exp_len(n, m), "access length wrong");
        end
        check(wcnt == ((n >= 2) ? 2 * (int'(n) - 1) : 0), "wait-progress width");
        check(first_w == ((n >= 2) ? 2 : -1), "wait-progress start");
    endtask

    task automatic run_acc(input logic [2:0] n, input logic ins, input logic [1:0] sp,
                           input logic wr, input logic [1:0] m, input int ev);
        rdy_mode = m;
        start_acc(n, ins, sp, wr);
        finish_acc(n, ins, m, ev);
    endtask

    task automatic wait_ack(input logic v);
        int i;
        for (i = 0; i < 40 && bus_hold_ack !== v; i++) begin
            @(negedge clk_sys);
        end
        check(bus_hold_ack === v, "hold acknowledge late");
        if (bus_hold_ack !== v) begin
            stop_test();
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int         k;
        logic [2:0] n;
        logic [1:0] m;
        rstn = 1'h0;
        {acc_req, acc_instr, acc_write, want_bus} = 4'h0;
        acc_sw_waits = 3'h0;
        acc_space = 2'h0;
        rdy_mode = 2'h1;
        off_n = 1'h1;
        prev_ok = 1'h0;
        prev_clk = 1'h0;
        void'($urandom(32'h0D42));
        repeat (2) @(negedge clk_sys);
        check({mem_strobe_n, io_strobe_n, wait_progress_out, instr_fetch_ind_n, bus_hold_ack,
               status_oe, ctl_oe} === 7'h78, "reset levels");
        @(negedge clk_sys);
        rstn = 1'h1;
        // Corner wait counts with the loop-back, then ready ignored or stalled
        for (k = 0; k < 4; k++) begin
            run_acc((k == 3) ? 3'h7 : 3'(k), 1'h1, 2'(k), 1'(k), 2'h2, 0);
        end
        run_acc(3'h0, 1'h0, 2'h1, 1'h0, 2'h0, 0);
        run_acc(3'h1, 1'h1, 2'h2, 1'h1, 2'h0, 0);
        run_acc(3'h4, 1'h0, 2'h0, 1'h0, 2'h0, 1);
        for (k = 0; k < 16; k++) begin
            n = 3'($urandom_range(7));
            m = (n < 2) ? 2'($urandom_range(2)) : 2'($urandom_range(2, 1));
            run_acc(n, 1'($urandom), 2'($urandom), 1'($urandom), m, 0);
        end
        // Hold granted while idle: access waits, bus floated
        want_bus = 1'h1;
        wait_ack(1'h1);
        repeat (2) @(negedge clk_sys);
        check(ctl_oe === 1'h0 && drive_bus === 1'h1, "bus not floated");
        rdy_mode = 2'h2;
        start_acc(3'h3, 1'h1, 2'h2, 1'h1);
        repeat (10) @(negedge clk_sys);
        check(io_strobe_n === 1'h1 && acc_done === 1'h0, "access taken in hold");
        want_bus = 1'h0;
        finish_acc(3'h3, 1'h1, 2'h2, 0);
        check(ctl_oe === 1'h1, "bus not driven after hold");
        // Hold asked during an access is granted only after it
        run_acc(3'h5, 1'h0, 2'h1, 1'h0, 2'h2, 2);
        wait_ack(1'h1);
        want_bus = 1'h0;
        wait_ack(1'h0);
        // Float control
        off_n = 1'h0;
        @(negedge clk_sys);
        check(status_oe === 1'h0 && ctl_oe === 1'h0, "float ignored");
        off_n = 1'h1;
        @(negedge clk_sys);
        check(status_oe === 1'h1 && ctl_oe === 1'h1, "float not lifted");
        stop_test();
    end
endmodule

// ==== logic/ebs_bus_status.sv ====
// Purpose : Hold handshake, wait-progress, fetch indicator and cycle clock
// Assumes : Core holds acc_req until acc_done; hold_req_n held until done
// Notes   : Pins have separate output enables; the pad muxes drive Z

`timescale 1ns/1ps

module ebs_bus_status (
    // Clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         rstn,
    // Core access request
    input  wire logic                         acc_req,
    input  wire logic [ebs_pkg::WAIT_W-1:0]   acc_sw_waits,
    input  wire logic                         acc_instr,
    input  wire logic [1:0]                   acc_space,
    input  wire logic                         acc_write,
    output logic                              acc_done,
    // External control inputs
    input  wire logic                         hold_req_n,
    input  wire logic                         ready,
    input  wire logic                         off_n,
    // Status pins and their enable
    output logic                              bus_hold_ack,
    output logic                              wait_progress_out,
    output logic                              instr_fetch_ind_n,
    output logic                              machine_cycle_clk_out,
    output logic                              status_oe,
    // Bus control pins and their enable
    output logic                              mem_strobe_n,
    output logic                              io_strobe_n,
    output logic                              data_space_sel_n,
    output logic                              prog_space_sel_n,
    output logic                              io_space_sel_n,
    output logic                              rd_wr,
    output logic                              ctl_oe
);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        ebs_pkg::ebs_state_e              st;      // Sequencer state
        logic [ebs_pkg::WAIT_W-1:0]       nwait;   // Programmed waits
        logic [ebs_pkg::WAIT_W-1:0]       wcnt;    // Waits left
        logic                             rdy_q;   // Ready at last boundary
        logic                             done;    // Access finished pulse
        logic                             ack;     // Hold acknowledge
        logic                             wp_n;    // Wait-progress level
        logic                             fetch_n;   // Fetch indicator
        logic                             mem_stb_n; // Memory strobe
        logic                             io_stb_n;  // I/O strobe
        logic                             dsel_n;    // Data space select
        logic                             psel_n;    // Program space select
        logic                             isel_n;    // I/O space select
        logic                             rw;      // High for read
        logic                             st_oe;   // Status pin enable
        logic                             c_oe;    // Control pin enable
    } ebs_state_s;

    ebs_state_s q_r;    // Registered state
    ebs_state_s q_nxt;  // Next state
    logic       mc_en;  // Machine cycle boundary enable
    logic       mc_clk; // Machine cycle clock level

    // ------------------------------------------------------------------
    // Machine cycle divider
    // ------------------------------------------------------------------
    ebs_mc_div u_div (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .mc_en   (mc_en),
        .mc_clk  (mc_clk)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Strobe, select, fetch, wait-progress and acknowledge levels change only on machine cycle boundaries
    always_comb begin
        q_nxt      = q_r;
        q_nxt.done = 1'b0;
        if (mc_en) begin
            // Ready is registered one cycle so a looped-back wait-progress
            // is seen as it stood in the wait before the last one
            q_nxt.rdy_q = ready;
            unique case (q_r.st)
                ebs_pkg::ST_IDLE: begin
                    if (!hold_req_n) begin
                        // Hold wins over a pending access
                        q_nxt.st  = ebs_pkg::ST_HOLD;
                        q_nxt.ack = 1'b1;
                    end else if (acc_req) begin
                        q_nxt.st       = ebs_pkg::ST_ADDR;
                        q_nxt.nwait    = acc_sw_waits;
                        q_nxt.fetch_n   = ~acc_instr;
                        q_nxt.rw        = ~acc_write;
                        q_nxt.psel_n    = ~(acc_space == ebs_pkg::SPACE_PROG);
                        q_nxt.dsel_n    = ~(acc_space == ebs_pkg::SPACE_DATA);
                        q_nxt.isel_n    = ~(acc_space == ebs_pkg::SPACE_IO);
                        q_nxt.mem_stb_n = (acc_space == ebs_pkg::SPACE_IO);
                        q_nxt.io_stb_n  = ~(acc_space == ebs_pkg::SPACE_IO);
                    end
                end
                ebs_pkg::ST_ADDR: begin
                    if (q_r.nwait == ebs_pkg::WAIT_NONE) begin
                        q_nxt.st = ebs_pkg::ST_IDLE;
                    end else begin
                        q_nxt.st   = ebs_pkg::ST_SWAIT;
                        q_nxt.wcnt = q_r.nwait;
                        // Start of the first software wait
                        if (q_r.nwait >= ebs_pkg::WAIT_MIN_RDY) begin
                            q_nxt.wp_n = 1'b0;
                        end
                    end
                end
                ebs_pkg::ST_SWAIT: begin
                    if (q_r.wcnt == ebs_pkg::WAIT_LAST) begin
                        // Waits complete; ready only counts for two or more
                        if (q_r.nwait >= ebs_pkg::WAIT_MIN_RDY && !q_r.rdy_q) begin
                            q_nxt.st = ebs_pkg::ST_XWAIT;
                        end else begin
                            q_nxt.st = ebs_pkg::ST_IDLE;
                        end
                    end else begin
                        q_nxt.wcnt = q_r.wcnt - ebs_pkg::WAIT_LAST;
                        // Entering the last software wait
                        if (q_r.wcnt == ebs_pkg::WAIT_MIN_RDY) begin
                            q_nxt.wp_n = 1'b1;
                        end
                    end
                end
                ebs_pkg::ST_XWAIT: begin
                    // Low ready costs one more cycle, then look again
                    if (q_r.rdy_q) begin
                        q_nxt.st = ebs_pkg::ST_IDLE;
                    end
                end
                ebs_pkg::ST_HOLD: begin
                    // Master keeps the request until it has left the bus
                    if (hold_req_n) begin
                        q_nxt.st  = ebs_pkg::ST_IDLE;
                        q_nxt.ack = 1'b0;
                    end
                end
            endcase
            // Leaving an access puts every strobe back to rest
            if (q_r.st != ebs_pkg::ST_IDLE && q_r.st != ebs_pkg::ST_HOLD
                && q_nxt.st == ebs_pkg::ST_IDLE) begin
                q_nxt.done     = 1'b1;
                q_nxt.fetch_n   = ebs_pkg::PIN_IDLE_N;
                q_nxt.mem_stb_n = ebs_pkg::PIN_IDLE_N;
                q_nxt.io_stb_n  = ebs_pkg::PIN_IDLE_N;
                q_nxt.dsel_n    = ebs_pkg::PIN_IDLE_N;
                q_nxt.psel_n    = ebs_pkg::PIN_IDLE_N;
                q_nxt.isel_n    = ebs_pkg::PIN_IDLE_N;
                q_nxt.rw       = ebs_pkg::PIN_IDLE_N;
                q_nxt.wp_n     = ebs_pkg::PIN_IDLE_N;
            end
        end
        // Enables follow float control, and c_oe also follows hold, on every clk_sys edge;
        // this costs one clk_sys of latency but keeps pins glitch free
        q_nxt.st_oe = off_n;
        q_nxt.c_oe  = off_n && (q_nxt.st != ebs_pkg::ST_HOLD);
    end

    // Register the whole state
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q_r          <= '0;
            q_r.st       <= ebs_pkg::ST_IDLE;
            q_r.ack      <= ebs_pkg::ACK_IDLE;
            q_r.wp_n     <= ebs_pkg::PIN_IDLE_N;
            q_r.fetch_n   <= ebs_pkg::PIN_IDLE_N;
            q_r.mem_stb_n <= ebs_pkg::PIN_IDLE_N;
            q_r.io_stb_n  <= ebs_pkg::PIN_IDLE_N;
            q_r.dsel_n    <= ebs_pkg::PIN_IDLE_N;
            q_r.psel_n    <= ebs_pkg::PIN_IDLE_N;
            q_r.isel_n    <= ebs_pkg::PIN_IDLE_N;
            q_r.rw       <= ebs_pkg::PIN_IDLE_N;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------------
    assign acc_done              = q_r.done;
    assign bus_hold_ack          = q_r.ack;
    assign wait_progress_out     = q_r.wp_n;
    assign instr_fetch_ind_n     = q_r.fetch_n;
    assign machine_cycle_clk_out = mc_clk;
    assign status_oe             = q_r.st_oe;
    assign mem_strobe_n          = q_r.mem_stb_n;
    assign io_strobe_n           = q_r.io_stb_n;
    assign data_space_sel_n      = q_r.dsel_n;
    assign prog_space_sel_n      = q_r.psel_n;
    assign io_space_sel_n        = q_r.isel_n;
    assign rd_wr                 = q_r.rw;
    assign ctl_oe                = q_r.c_oe;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_ack_float;
        @(posedge clk_sys) disable iff (!rstn)
        bus_hold_ack |-> !ctl_oe && q_r.st == ebs_pkg::ST_HOLD;
    endproperty
    a_ack_float: assert property (p_ack_float)
        else $error("hold ack while bus driven");

    property p_wp_first;
        @(posedge clk_sys) disable iff (!rstn)
        mc_en && q_r.st == ebs_pkg::ST_ADDR && q_r.nwait >= ebs_pkg::WAIT_MIN_RDY
        |=> !wait_progress_out && q_r.st == ebs_pkg::ST_SWAIT;
    endproperty
    a_wp_first: assert property (p_wp_first)
        else $error("wait progress not low at first wait");

    property p_wp_last;
        @(posedge clk_sys) disable iff (!rstn)
        mc_en && q_r.st == ebs_pkg::ST_SWAIT && q_r.wcnt == ebs_pkg::WAIT_MIN_RDY
        |=> wait_progress_out && q_r.wcnt == ebs_pkg::WAIT_LAST;
    endproperty
    a_wp_last: assert property (p_wp_last)
        else $error("wait progress not high at last wait");

    property p_loop_one;
        @(posedge clk_sys) disable iff (!rstn)
        mc_en && q_r.st == ebs_pkg::ST_XWAIT && q_r.rdy_q |=> acc_done;
    endproperty
    a_loop_one: assert property (p_loop_one)
        else $error("access not ended after ready high");

    property p_fetch_idle;
        @(posedge clk_sys) disable iff (!rstn)
        q_r.st == ebs_pkg::ST_IDLE || q_r.st == ebs_pkg::ST_HOLD |-> instr_fetch_ind_n;
    endproperty
    a_fetch_idle: assert property (p_fetch_idle)
        else $error("fetch indicator low with no access");

    property p_clk_tog;
        @(posedge clk_sys) disable iff (!rstn)
        mc_en |=> $rose(machine_cycle_clk_out) ##1 $fell(machine_cycle_clk_out);
    endproperty
    a_clk_tog: assert property (p_clk_tog)
        else $error("cycle clock not toggling");

    property p_off_float;
        @(posedge clk_sys) disable iff (!rstn)
        !off_n |=> !status_oe && !ctl_oe;
    endproperty
    a_off_float: assert property (p_off_float)
        else $error("pins driven while float control low");

    property p_no_rdy;
        @(posedge clk_sys) disable iff (!rstn)
        mc_en && q_r.st == ebs_pkg::ST_SWAIT && q_r.wcnt == ebs_pkg::WAIT_LAST
        && q_r.nwait < ebs_pkg::WAIT_MIN_RDY |=> acc_done;
    endproperty
    a_no_rdy: assert property (p_no_rdy)
        else $error("ready used with fewer than two waits");

    property p_rdy_low;
        @(posedge clk_sys) disable iff (!rstn)
        mc_en && q_r.st == ebs_pkg::ST_XWAIT && !q_r.rdy_q
        |=> q_r.st == ebs_pkg::ST_XWAIT && !acc_done;
    endproperty
    a_rdy_low: assert property (p_rdy_low)
        else $error("access ended with ready low");

    property p_hold_float;
        @(posedge clk_sys) disable iff (!rstn)
        $rose(bus_hold_ack) |-> !ctl_oe && mem_strobe_n && io_strobe_n;
    endproperty
    a_hold_float: assert property (p_hold_float)
        else $error("control pins driven in hold");

endmodule

// ==== logic/ebs_mc_div.sv ====
// Purpose : Machine-cycle divider, makes the cycle clock level and enable
// Assumes : MC_DIV is 2, so the level simply toggles every rising clk_sys edge
// Notes   : mc_en is high in the clk_sys cycle before each rising edge

`timescale 1ns/1ps

module ebs_mc_div (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // Machine cycle outputs
    output logic      mc_en,
    output logic      mc_clk
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic clk_lvl;  // Cycle clock level
    } ebs_div_s;

    ebs_div_s q_r;      // Registered state
    ebs_div_s q_nxt;    // Next state

    // Level toggles each clk_sys, giving one rising edge per machine cycle
    always_comb begin
        q_nxt         = q_r;
        q_nxt.clk_lvl = ~q_r.clk_lvl;
    end

    // Register the divider
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Enable marks the clk_sys edge on which the level rises
    assign mc_en  = ~q_r.clk_lvl;
    assign mc_clk = q_r.clk_lvl;

endmodule

// ==== logic/ebs_pkg.sv ====
// Purpose : Shared constants and types for the external bus status block
// Assumes : clk_sys at 40 MHz, one machine cycle is two clk_sys periods
// Notes   : Every figure used by the design is named here once

package ebs_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_SYS_PERIOD_NS = 25;  // clk_sys period
    localparam int MC_PERIOD_NS      = 50;  // Machine cycle period
    // Machine cycle length in clk_sys cycles, derived from the two periods
    localparam int MC_DIV            = MC_PERIOD_NS / CLK_SYS_PERIOD_NS;

    // ------------------------------------------------------------------
    // Wait-state figures
    // ------------------------------------------------------------------
    localparam int       WAIT_W        = 3;       // Width of the wait count
    localparam logic [2:0] WAIT_MIN_RDY = 3'h2;   // Waits needed to use ready
    localparam logic [2:0] WAIT_LAST    = 3'h1;   // Count left in last wait
    localparam logic [2:0] WAIT_NONE    = 3'h0;   // No software waits

    // ------------------------------------------------------------------
    // Address space codes
    // ------------------------------------------------------------------
    localparam logic [1:0] SPACE_PROG = 2'h0;     // Program space
    localparam logic [1:0] SPACE_DATA = 2'h1;     // Data space
    localparam logic [1:0] SPACE_IO   = 2'h2;     // I/O space

    // ------------------------------------------------------------------
    // Reset values of the pins (inactive levels)
    // ------------------------------------------------------------------
    localparam logic PIN_IDLE_N = 1'h1;           // Active-low pins at rest
    localparam logic ACK_IDLE   = 1'h0;           // Hold acknowledge at rest

    // Bus sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_SWAIT,
        ST_XWAIT,
        ST_HOLD
    } ebs_state_e;

endpackage
